// *** hw/eth_stat_pkg.sv ***
/*
  Package for the Ethernet status and statistics slice: register offsets,
  companion view offsets, field positions, reset values and bus constants.
  Assumes a 32-bit Avalon-MM register bus with byte enables.
*/
package eth_stat_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, each register a 16-byte block of four view words)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ALIGN_STAT = 8'h20;
  localparam logic [7:0] ADDR_STATION_W0 = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h50;

  // Companion views: plain, clear, set, invert
  localparam logic [1:0] VIEW_PLAIN = 2'h0;
  localparam logic [1:0] VIEW_CLR = 2'h1;
  localparam logic [1:0] VIEW_SET = 2'h2;
  localparam logic [1:0] VIEW_INV = 2'h3;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 15;
  localparam int STAT_TX_ACTIVE_BIT = 6;
  localparam int STAT_RX_ACTIVE_BIT = 5;
  localparam int IRQ_TX_DONE_BIT = 0;
  localparam int IRQ_RX_DONE_BIT = 1;
  localparam int IRQ_ALIGN_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // ----------------------------------------------------------------
  // Reset values and bus constants
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ALIGN_COUNT_RESET = 16'h0000;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam int WAIT_CYCLES = 1;

endpackage

// *** hw/eth_status_counters.sv ***
/*
  Ethernet status and statistics slice: activity flags, clear-on-read
  misaligned frame counter, station address octets five and six, and
  a sticky interrupt status with mask.
  Assumes an Avalon-MM master that holds its request until waitrequest
  is low, and engine event inputs synchronous to clk_in.
*/
// The address map and the Avalon-MM register port were chosen for this implementation.
// Contract
// R1: Tx activity flag high while sending
// R2: Rx activity flag high while receiving
// R3: Tx flag may fall without done
// R4: Rx flag may fall without done
// R5: Both flags cleared while controller off
// R6: Status bits 4..0 read zero
// R7: Count FCS error with odd bit length
// R8: Counter in 15..0, upper zero, resets zero
// R9: Clear after read unless low bytes disabled
// R10: Only receive events change counter
// R11: Software writes counter only for debug
// R12: Bits 15..8 hold sixth octet
// R13: Bits 7..0 fifth octet, upper zero
// R14: Station address ignores 8-bit accesses
// R15: Station address loaded from factory value
// R16: Increment during clearing read gives one
`timescale 1ns/10ps
`default_nettype none

module eth_status_counters #(
  parameter logic [15:0] FACTORY_STATION_ADDR = 16'h0000  // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Engine activity and events
  input wire logic tx_busy_in,
  input wire logic rx_busy_in,
  input wire logic tx_done_in,
  input wire logic rx_done_in,
  input wire logic rx_frame_end_in,
  input wire logic rx_fcs_error_in,
  input wire logic [2:0] rx_bit_residue_in,
  // Controller view
  output logic controller_on_out,
  output logic [15:0] station_octets_out,
  output logic tx_active_flag_out,
  output logic rx_active_flag_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [15:0] control_ff;
  logic tx_active_flag_ff;
  logic rx_active_flag_ff;
  logic [15:0] misaligned_frame_count_ff;
  logic [15:0] station_ff;
  logic station_loaded_ff;
  logic [2:0] irq_status_ff;
  logic [2:0] irq_mask_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic irq_ff;

  logic [7:0] reg_base;
  logic [1:0] view;
  logic access;
  logic wr_go;
  logic rd_go;
  logic lo_bytes_en;
  logic wide_access;
  logic [15:0] wmask;
  logic [15:0] wdata16;
  logic misaligned_evt;
  logic [2:0] irq_events;
  logic sel_control;
  logic sel_align;
  logic sel_station;
  logic sel_irq_status;
  logic sel_irq_mask;
  logic align_clear;
  logic irq_pending;
  logic [31:0] nxt_rdata;
  logic [15:0] nxt_control;
  logic [15:0] nxt_misaligned_frame_count;
  logic [15:0] nxt_station;
  logic [2:0] nxt_irq_status;
  logic [2:0] nxt_irq_mask;

  assign reg_base = {avs_address_in[7:4], 4'h0};
  assign view = avs_address_in[3:2];
  assign access = (avs_read_in || avs_write_in) && !ack_ff;
  assign wr_go = avs_write_in && !ack_ff;
  assign rd_go = avs_read_in && !ack_ff;
  assign lo_bytes_en = |avs_byteenable_in[1:0];
  // 16-bit or 32-bit only: both low lanes, both high lanes, or all
  assign wide_access = (avs_byteenable_in == 4'hf) || (avs_byteenable_in == 4'h3)
                       || (avs_byteenable_in == 4'hc);
  assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wdata16 = avs_writedata_in[15:0];
  assign misaligned_evt = rx_frame_end_in && rx_fcs_error_in
                          && (rx_bit_residue_in != 3'h0);  // [R7] [R10]
  assign irq_events = {misaligned_evt, rx_done_in, tx_done_in};

  // ----------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------
  // Status register has no select: writes to it are ignored
  assign sel_control = (reg_base == eth_stat_pkg::ADDR_CONTROL_ONE);
  assign sel_align = (reg_base == eth_stat_pkg::ADDR_ALIGN_STAT);
  assign sel_station = (reg_base == eth_stat_pkg::ADDR_STATION_W0);
  assign sel_irq_status = (reg_base == eth_stat_pkg::ADDR_IRQ_STATUS);
  assign sel_irq_mask = (reg_base == eth_stat_pkg::ADDR_IRQ_MASK);
  // Reads with both low lanes off leave the counter alone
  assign align_clear = rd_go && sel_align && lo_bytes_en;  // [R9]

  // Apply a companion view to a 16-bit field
  function automatic logic [15:0] apply_view(input logic [15:0] cur,
                                             input logic [1:0] v,
                                             input logic [15:0] d,
                                             input logic [15:0] m);
    logic [15:0] res;
    res = cur;
    case (v)
      eth_stat_pkg::VIEW_PLAIN: res = (cur & ~m) | (d & m);
      eth_stat_pkg::VIEW_CLR: res = cur & ~(d & m);
      eth_stat_pkg::VIEW_SET: res = cur | (d & m);
      eth_stat_pkg::VIEW_INV: res = cur ^ (d & m);
      default: res = cur;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= access;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_ff <= eth_stat_pkg::READ_ZERO;
    end else if (rd_go) begin
      // Captured when the read is taken, stands until the next one
      rdata_ff <= nxt_rdata;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = eth_stat_pkg::READ_ZERO;
    case (reg_base)
      eth_stat_pkg::ADDR_CONTROL_ONE: begin
        nxt_rdata = {16'h0000, control_ff};
      end
      eth_stat_pkg::ADDR_STATUS: begin
        // Bits 4..0 and the upper half stay zero
        nxt_rdata[eth_stat_pkg::STAT_TX_ACTIVE_BIT] = tx_active_flag_ff;  // [R1] [R6]
        nxt_rdata[eth_stat_pkg::STAT_RX_ACTIVE_BIT] = rx_active_flag_ff;  // [R2] [R6]
      end
      eth_stat_pkg::ADDR_ALIGN_STAT: begin
        nxt_rdata = {16'h0000, misaligned_frame_count_ff};  // [R8]
      end
      eth_stat_pkg::ADDR_STATION_W0: begin
        nxt_rdata = {16'h0000, station_ff};  // [R13]
      end
      eth_stat_pkg::ADDR_IRQ_STATUS: begin
        nxt_rdata = {29'h0000_0000, irq_status_ff};
      end
      eth_stat_pkg::ADDR_IRQ_MASK: begin
        nxt_rdata = {29'h0000_0000, irq_mask_ff};
      end
      default: begin
        nxt_rdata = eth_stat_pkg::READ_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control register one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      control_ff <= eth_stat_pkg::CTRL_RESET;
    end else begin
      control_ff <= nxt_control;
    end
  end

  always_comb begin
    nxt_control = control_ff;
    if (wr_go && sel_control) begin
      nxt_control = apply_view(control_ff, view, wdata16, wmask);
    end
  end

  // ----------------------------------------------------------------
  // Activity flags follow engines, forced low while off
  // ----------------------------------------------------------------
  // Flags fall with busy alone; no done event is needed
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_active_flag_ff <= 1'b0;
    end else if (!control_ff[eth_stat_pkg::CTRL_ON_BIT]) begin
      tx_active_flag_ff <= 1'b0;  // [R5]
    end else begin
      tx_active_flag_ff <= tx_busy_in;  // [R1] [R3]
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_active_flag_ff <= 1'b0;
    end else if (!control_ff[eth_stat_pkg::CTRL_ON_BIT]) begin
      rx_active_flag_ff <= 1'b0;  // [R5]
    end else begin
      rx_active_flag_ff <= rx_busy_in;  // [R2] [R4]
    end
  end

  // ----------------------------------------------------------------
  // Misaligned frame counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      misaligned_frame_count_ff <= eth_stat_pkg::ALIGN_COUNT_RESET;  // [R8]
    end else begin
      misaligned_frame_count_ff <= nxt_misaligned_frame_count;
    end
  end

  // Debug write beats a same-cycle increment
  always_comb begin
    nxt_misaligned_frame_count = misaligned_frame_count_ff;
    if (align_clear) begin
      // Clearing read; a same-cycle event survives as one
      nxt_misaligned_frame_count = misaligned_evt ? 16'h0001 : 16'h0000;  // [R9] [R16]
    end else if (wr_go && sel_align) begin
      // Debug write path
      nxt_misaligned_frame_count = apply_view(misaligned_frame_count_ff, view,
                                              wdata16, wmask);  // [R11]
    end else if (misaligned_evt) begin
      nxt_misaligned_frame_count = misaligned_frame_count_ff + 16'h0001;  // [R7]
    end
  end

  // ----------------------------------------------------------------
  // Station address octets five and six
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      station_ff <= 16'h0000;
      station_loaded_ff <= 1'b0;
    end else begin
      station_ff <= nxt_station;
      station_loaded_ff <= 1'b1;
    end
  end

  // Factory value lands on the first edge after reset
  always_comb begin
    nxt_station = station_ff;
    if (!station_loaded_ff) begin
      nxt_station = FACTORY_STATION_ADDR;  // [R15]
    end else if (wr_go && sel_station && wide_access) begin
      // Byte-wide writes fall through and are answered only
      nxt_station = apply_view(station_ff, view, wdata16, wmask);  // [R12] [R13] [R14]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status_ff <= 3'h0;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  always_comb begin
    nxt_irq_status = irq_status_ff | irq_events;
    if (wr_go && sel_irq_status) begin
      // Write one to clear; new events win
      nxt_irq_status = (irq_status_ff & ~avs_writedata_in[2:0]) | irq_events;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_mask_ff <= eth_stat_pkg::IRQ_MASK_RESET;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  always_comb begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_go && sel_irq_mask) begin
      nxt_irq_mask = avs_writedata_in[2:0];
    end
  end

  // Level request, one cycle behind status and mask
  assign irq_pending = |(irq_status_ff & irq_mask_ff);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irq_pending;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    avs_readdata_out = rdata_ff;
    avs_waitrequest_out = !ack_ff;
    controller_on_out = control_ff[eth_stat_pkg::CTRL_ON_BIT];
    station_octets_out = station_ff;
    tx_active_flag_out = tx_active_flag_ff;
    rx_active_flag_out = rx_active_flag_ff;
    irq_out = irq_ff;
  end

endmodule
`default_nettype wire

// *** dv/eth_stat_chk_sva.sv ***
/* Checker for the Ethernet status slice, on its top ports only.
   Assumes a bind onto eth_status_counters. */
`timescale 1ns/10ps
`default_nettype none
module eth_stat_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register bus
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Engines and controller view
  input wire logic tx_busy_in,
  input wire logic rx_busy_in,
  input wire logic controller_on_out,
  input wire logic [15:0] station_octets_out,
  input wire logic tx_active_flag_out,
  input wire logic rx_active_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic ans;
  assign ans = avs_read_in && !avs_waitrequest_out;
  chk_tx_busy_high: assert property (tx_busy_in && controller_on_out && !avs_write_in
    |=> tx_active_flag_out) else $error("tx flag low while busy");
  chk_tx_idle_low: assert property (!tx_busy_in |=> !tx_active_flag_out)
    else $error("tx flag high while idle");
  chk_rx_busy_high: assert property (rx_busy_in && controller_on_out && !avs_write_in
    |=> rx_active_flag_out) else $error("rx flag low while busy");
  chk_rx_idle_low: assert property (!rx_busy_in |=> !rx_active_flag_out)
    else $error("rx flag high while idle");
  chk_flags_off: assert property (!controller_on_out
    |=> !tx_active_flag_out && !rx_active_flag_out) else $error("flag set while off");
  chk_status_low: assert property (ans && avs_address_in == eth_stat_pkg::ADDR_STATUS
    |-> avs_readdata_out[4:0] == 5'h00) else $error("status low bits set");
  chk_count_upper: assert property (ans && avs_address_in[7:4] == 4'h2
    |-> avs_readdata_out[31:16] == 16'h0000) else $error("counter upper bits set");
  chk_station_read: assert property (ans && avs_address_in == eth_stat_pkg::ADDR_STATION_W0
    |-> avs_readdata_out == {16'h0000, station_octets_out}) else $error("station read wrong");
  chk_byte_ignore: assert property (avs_write_in && avs_waitrequest_out
    && avs_address_in[7:4] == 4'h3 && $countones(avs_byteenable_in) == 1
    |=> $stable(station_octets_out)) else $error("byte write changed station");
  chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("answer timing wrong");
endmodule
bind eth_status_counters eth_stat_chk u_chk (.clk_in, .resetn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .tx_busy_in, .rx_busy_in, .controller_on_out, .station_octets_out, .tx_active_flag_out,
  .rx_active_flag_out);
`default_nettype wire

// *** dv/tb_top.sv ***
/* Self-checking bench for the Ethernet status slice.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] FACT = 16'hA5C3;  // Arbitrary value
  logic clk_in = 1'h0, resetn_in = 1'h0, rd = 1'h0, wr = 1'h0, txb = 1'h0, rxb = 1'h0;
  logic txd = 1'h0, rxd = 1'h0, fe = 1'h0, fcs = 1'h0, wt, on, txf, rxf, irq;
  logic [2:0] res = 3'h0;
  logic [3:0] be = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [15:0] lf = 16'h002B, sv, sta, cnt;
  logic [31:0] wd = 32'h0000_0000, rdat, rv;
  int errors = 0, total_checks = 0, cyc = 0;
  eth_status_counters #(.FACTORY_STATION_ADDR(FACT)) dut (.clk_in(clk_in),
    .resetn_in(resetn_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .tx_busy_in(txb), .rx_busy_in(rxb), .tx_done_in(txd),
    .rx_done_in(rxd), .rx_frame_end_in(fe), .rx_fcs_error_in(fcs), .rx_bit_residue_in(res),
    .controller_on_out(on), .station_octets_out(sta), .tx_active_flag_out(txf),
    .rx_active_flag_out(rxf), .irq_out(irq));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] view(input int v, input logic [15:0] s, d);
    case (v)
      0: return d;
      1: return s & ~d;
      2: return s | d;
      default: return s ^ d;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    @(posedge clk_in);
    while (wt !== 1'h0) @(posedge clk_in);
    rv = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000, b);
    chk(rv, e);
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'hF, 32'h0000_0000);
    rdc(eth_stat_pkg::ADDR_STATION_W0, 4'hF, {16'h0000, FACT});
    bus(1'h1, eth_stat_pkg::ADDR_CONTROL_ONE, 32'h0000_8000, 4'hF);
    chk({31'h0, on}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      txb <= lf[0];
      rxb <= lf[1];
      repeat (3) @(posedge clk_in);
      rdc(eth_stat_pkg::ADDR_STATUS, 4'hF, {25'h0, lf[0], lf[1], 5'h00});
    end
    txb <= 1'h1;
    rxb <= 1'h1;
    bus(1'h1, eth_stat_pkg::ADDR_CONTROL_ONE, 32'h0000_0000, 4'hF);
    chk({29'h0, on, txf, rxf}, 32'h0000_0000);
    txb <= 1'h0;
    rxb <= 1'h0;
    rdc(eth_stat_pkg::ADDR_IRQ_STATUS, 4'hF, 32'h0000_0000);
    bus(1'h1, eth_stat_pkg::ADDR_CONTROL_ONE, 32'h0000_8000, 4'hF);
    $display("flags test done");
    cnt = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      lf = nx(lf);
      fe <= 1'h1;
      fcs <= lf[0];
      res <= lf[3:1];
      txd <= lf[4];
      if (lf[0] && lf[3:1] != 3'h0) cnt++;
      @(posedge clk_in);
    end
    fe <= 1'h0;
    txd <= 1'h0;
    rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'hC, {16'h0000, cnt});
    rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'h3, {16'h0000, cnt});
    rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'hF, 32'h0000_0000);
    bus(1'h1, eth_stat_pkg::ADDR_ALIGN_STAT + 8'h08, 32'h0000_0005, 4'h3);
    rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'hF, 32'h0000_0005);
    fe <= 1'h1;
    fcs <= 1'h1;
    res <= 3'h1;
    fork
      rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'hF, 32'h0000_0000);
      begin
        @(posedge clk_in);
        fe <= 1'h0;
      end
    join
    rdc(eth_stat_pkg::ADDR_ALIGN_STAT, 4'hF, 32'h0000_0001);
    $display("counter test done");
    bus(1'h1, eth_stat_pkg::ADDR_IRQ_MASK, 32'h0000_0002, 4'hF);
    bus(1'h1, eth_stat_pkg::ADDR_IRQ_STATUS, 32'h0000_0007, 4'hF);
    chk({31'h0, irq}, 32'h0000_0000);
    rxd <= 1'h1;
    @(posedge clk_in);
    rxd <= 1'h0;
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'h1, eth_stat_pkg::ADDR_IRQ_MASK, 32'h0000_0000, 4'hF);
    chk({31'h0, irq}, 32'h0000_0000);
    rdc(eth_stat_pkg::ADDR_IRQ_STATUS, 4'hF, 32'h0000_0002);
    rdc(8'h60, 4'hF, 32'h0000_0000);
    $display("interrupt test done");
    sv = FACT;
    for (int v = 0; v < 4; v++) begin
      lf = nx(lf);
      bus(1'h1, eth_stat_pkg::ADDR_STATION_W0 + 8'(4 * v), {~lf, lf}, v[0] ? 4'h3 : 4'hF);
      sv = view(v, sv, lf);
      rdc(eth_stat_pkg::ADDR_STATION_W0, 4'hF, {16'h0000, sv});
    end
    bus(1'h1, eth_stat_pkg::ADDR_STATION_W0, {16'h0000, ~sv}, 4'h1);
    chk({16'h0000, sta}, {16'h0000, sv});
    $display("station test done");
    summarize();
  end
endmodule
`default_nettype wire
